// ===== include/cbp_pkg.sv
// shared constants and types for the processor bus ports
`default_nettype none
package cbp_pkg;
	// ==========================================================
	// widths and sizes
	localparam int unsigned WORD_W        = 16;
	localparam int unsigned HDR_W         = 2;
	localparam int unsigned IO_LANES      = 2;
	localparam int unsigned REQ_N         = 2;
	localparam int unsigned MEM_WORDS_2K  = 2048;
	localparam int unsigned MEM_WORDS_4K  = 4096;
	// beats per transfer: one header beat then eight data beats
	localparam int unsigned BEATS         = 1 + WORD_W / IO_LANES;
	// ==========================================================
	// timing: io clock half period and system clock divider
	localparam int unsigned CLK_NS        = 10;
	localparam int unsigned IO_HALF_NS    = 40;
	localparam int unsigned IO_HALF_CYC   = (IO_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SYS_HALF_NS   = 20;
	localparam int unsigned SYS_HALF_CYC  = (SYS_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned MEM_CYC_NS    = 960;
	localparam int unsigned MEM_PHASE_CYC = MEM_CYC_NS / CLK_NS / 4;
	// ==========================================================
	// memory cycle kinds, carried on the control lines
	typedef enum logic [1:0] {
		CBP_MEM_READ    = 2'h0,
		CBP_MEM_WRITE   = 2'h1,
		CBP_MEM_RMW     = 2'h2,
		CBP_MEM_REFRESH = 2'h3
	} cbp_mem_op_t;
	// control line bit positions
	localparam int unsigned CTL_ADDR  = 0;
	localparam int unsigned CTL_RD    = 1;
	localparam int unsigned CTL_WR    = 2;
	localparam int unsigned CTL_REF   = 3;
endpackage
`default_nettype wire

// ===== include/cbp_if.sv
// interface joining the processor end and the peripheral/memory end
`default_nettype none
interface cbp_if;
	import cbp_pkg::*;
	// memory path: three-signal form of each wired-or bit
	logic [WORD_W-1:0]   mad_cpu_o;
	logic                mad_cpu_oe;
	logic [WORD_W-1:0]   mad_dev_o;
	logic                mad_dev_oe;
	logic [WORD_W-1:0]   mad;
	logic [3:0]          mctl;
	// io link
	logic [IO_LANES-1:0] iod_cpu_o;
	logic                iod_cpu_oe;
	logic [IO_LANES-1:0] iod_dev_o;
	logic                iod_dev_oe;
	logic [IO_LANES-1:0] iod;
	logic                ioclk_cpu_o;
	logic                ioclk_cpu_oe;
	logic                ioclk_dev_o;
	logic                ioclk_dev_oe;
	logic                ioclk;
	logic                sysclk;
	logic                clear;
	logic [REQ_N-1:0]    req;
	logic [REQ_N-1:0]    pri;
	// wired-or resolution: undriven lines rest low
	assign mad   = (mad_cpu_oe ? mad_cpu_o : '0) | (mad_dev_oe ? mad_dev_o : '0);
	assign iod   = (iod_cpu_oe ? iod_cpu_o : '0) | (iod_dev_oe ? iod_dev_o : '0);
	assign ioclk = (ioclk_cpu_oe & ioclk_cpu_o) | (ioclk_dev_oe & ioclk_dev_o);
	modport cpu (
		output mad_cpu_o, mad_cpu_oe, mctl, iod_cpu_o, iod_cpu_oe,
		output ioclk_cpu_o, ioclk_cpu_oe, sysclk, clear,
		input  mad, iod, ioclk, req, pri
	);
	modport dev (
		output mad_dev_o, mad_dev_oe, iod_dev_o, iod_dev_oe,
		output ioclk_dev_o, ioclk_dev_oe, req, pri,
		input  mad, mctl, iod, ioclk, sysclk, clear
	);
endinterface
`default_nettype wire

// ===== hw/cbp_cpu_end.sv
// processor end: memory bus master and io link master
`default_nettype none
module cbp_cpu_end
	import cbp_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              clk_en_i,
	cbp_if.cpu                     bus,
	input  wire logic              mem_req_i,
	input  wire logic [1:0]        mem_op_i,
	input  wire logic [WORD_W-1:0] mem_addr_i,
	input  wire logic [WORD_W-1:0] mem_wdata_i,
	output logic                   mem_busy_o,
	output logic                   mem_done_o,
	output logic [WORD_W-1:0]      mem_rdata_o,
	input  wire logic              io_req_i,
	input  wire logic              io_dir_out_i,
	input  wire logic [HDR_W-1:0]  io_hdr_i,
	input  wire logic [WORD_W-1:0] io_wdata_i,
	output logic                   io_busy_o,
	output logic                   io_done_o,
	output logic [WORD_W-1:0]      io_rdata_o,
	input  wire logic              clear_req_i,
	input  wire logic              ovr_i,
	input  wire logic [3:0]        ovr_mctl_i,
	output logic [REQ_N-1:0]       req_o,
	output logic [REQ_N-1:0]       pri_o
);
	// ==========================================================
	// memory sequencer: address phase, then data phases; refresh skips the address phase
	typedef enum logic [2:0] {
		CBP_M_IDLE = 3'h0,
		CBP_M_ADDR = 3'h1,
		CBP_M_RD   = 3'h2,
		CBP_M_WR   = 3'h3,
		CBP_M_REF  = 3'h4
	} cbp_mst_t;
	cbp_mst_t          m_st_q, m_st_d;
	logic [1:0]        m_op_q, m_op_d;
	logic [WORD_W-1:0] m_addr_q, m_addr_d, m_wd_q, m_wd_d, m_rd_q, m_rd_d;
	logic [7:0]        m_cnt_q, m_cnt_d;
	logic              m_done_q, m_done_d, m_oe_q, m_oe_d, m_busy_q, m_busy_d;
	logic [WORD_W-1:0] m_out_q, m_out_d;
	logic [3:0]        m_ctl_q, m_ctl_d;

	always_comb begin
		m_st_d   = m_st_q;
		m_op_d   = m_op_q;
		m_addr_d = m_addr_q;
		m_wd_d   = m_wd_q;
		m_rd_d   = m_rd_q;
		m_cnt_d  = m_cnt_q;
		m_done_d = 1'b0;
		m_oe_d   = 1'b0;
		m_out_d  = '0;
		m_ctl_d  = '0;
		if (m_cnt_q != 8'h00) begin
			m_cnt_d = m_cnt_q - 8'h01;
		end
		unique case (m_st_q)
			CBP_M_IDLE: begin
				if (mem_req_i && !ovr_i) begin
					m_op_d   = mem_op_i;
					m_addr_d = mem_addr_i;
					m_wd_d   = mem_wdata_i;
					m_cnt_d  = 8'(MEM_PHASE_CYC - 1);
					m_st_d   = (mem_op_i == CBP_MEM_REFRESH) ? CBP_M_REF : CBP_M_ADDR;
				end
			end
			CBP_M_ADDR: begin
				m_oe_d  = 1'b1;
				m_out_d = m_addr_q;
				m_ctl_d[CTL_ADDR] = 1'b1;
				if (m_cnt_q == 8'h00) begin
					m_cnt_d = 8'(MEM_PHASE_CYC - 1);
					m_st_d  = (m_op_q == CBP_MEM_WRITE) ? CBP_M_WR : CBP_M_RD;
				end
			end
			CBP_M_RD: begin
				m_ctl_d[CTL_RD] = 1'b1;
				if (m_cnt_q == 8'h00) begin
					m_rd_d  = bus.mad;
					m_cnt_d = 8'(MEM_PHASE_CYC - 1);
					if (m_op_q == CBP_MEM_RMW) begin
						m_wd_d = mem_wdata_i;
						m_st_d = CBP_M_WR;
					end else begin
						m_done_d = 1'b1;
						m_st_d   = CBP_M_IDLE;
					end
				end
			end
			CBP_M_WR: begin
				m_oe_d  = 1'b1;
				m_out_d = m_wd_q;
				m_ctl_d[CTL_WR] = 1'b1;
				if (m_cnt_q == 8'h00) begin
					m_done_d = 1'b1;
					m_st_d   = CBP_M_IDLE;
				end
			end
			CBP_M_REF: begin
				m_ctl_d[CTL_REF] = 1'b1;
				if (m_cnt_q == 8'h00) begin
					m_done_d = 1'b1;
					m_st_d   = CBP_M_IDLE;
				end
			end
			default: m_st_d = CBP_M_IDLE;
		endcase
		// override from console, restart or loader takes the controls
		if (ovr_i) begin
			m_ctl_d = ovr_mctl_i;
			m_oe_d  = 1'b0;
		end
		m_busy_d = (m_st_d != CBP_M_IDLE);
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			m_st_q   <= CBP_M_IDLE;
			m_op_q   <= 2'h0;
			m_addr_q <= '0;
			m_wd_q   <= '0;
			m_rd_q   <= '0;
			m_cnt_q  <= 8'h00;
			m_done_q <= 1'b0;
			m_oe_q   <= 1'b0;
			m_out_q  <= '0;
			m_ctl_q  <= 4'h0;
			m_busy_q <= 1'b0;
		end else if (clk_en_i) begin
			m_st_q   <= m_st_d;
			m_op_q   <= m_op_d;
			m_addr_q <= m_addr_d;
			m_wd_q   <= m_wd_d;
			m_rd_q   <= m_rd_d;
			m_cnt_q  <= m_cnt_d;
			m_done_q <= m_done_d;
			m_oe_q   <= m_oe_d;
			m_out_q  <= m_out_d;
			m_ctl_q  <= m_ctl_d;
			m_busy_q <= m_busy_d;
		end
	end
	assign bus.mad_cpu_o  = m_out_q;
	assign bus.mad_cpu_oe = m_oe_q;
	assign bus.mctl       = m_ctl_q;
	assign mem_busy_o     = m_busy_q;
	assign mem_done_o     = m_done_q;
	assign mem_rdata_o    = m_rd_q;

	// ==========================================================
	// io link: header beat then eight data beats, two bits each
	logic [7:0]        io_div_q, io_div_d;
	logic              io_clk_q, io_clk_d, io_act_q, io_act_d, io_out_q, io_out_d;
	logic [3:0]        io_beat_q, io_beat_d;
	logic [WORD_W+HDR_W-1:0] io_sh_q, io_sh_d;
	logic [WORD_W-1:0] io_rd_q, io_rd_d;
	logic              io_done_q, io_done_d, io_oe_q, io_oe_d;
	logic [IO_LANES-1:0] io_dat_q, io_dat_d;
	logic [7:0]        sys_div_q, sys_div_d;
	logic              sys_q, sys_d, clr_q, clr_d;
	logic [REQ_N-1:0]  rq1_q, rq2_q, pr1_q, pr2_q;

	always_comb begin
		io_div_d  = io_div_q;
		io_clk_d  = io_clk_q;
		io_act_d  = io_act_q;
		io_out_d  = io_out_q;
		io_beat_d = io_beat_q;
		io_sh_d   = io_sh_q;
		io_rd_d   = io_rd_q;
		io_done_d = 1'b0;
		io_oe_d   = io_oe_q;
		io_dat_d  = io_dat_q;
		if (!io_act_q) begin
			io_clk_d = 1'b0;
			io_oe_d  = 1'b0;
			if (io_req_i && !ovr_i) begin
				io_act_d  = 1'b1;
				io_out_d  = io_dir_out_i;
				io_sh_d   = {io_hdr_i, io_wdata_i};
				io_beat_d = 4'h0;
				io_div_d  = 8'(IO_HALF_CYC - 1);
				io_oe_d   = 1'b1;
				io_dat_d  = io_hdr_i;
			end
		end else if (io_div_q != 8'h00) begin
			io_div_d = io_div_q - 8'h01;
		end else begin
			io_div_d = 8'(IO_HALF_CYC - 1);
			io_clk_d = !io_clk_q;
			if (!io_clk_q) begin
				// rising edge: sample what was launched on the falling edge
				if (io_beat_q != 4'h0) begin
					// far end launches a few cycles after the fall, so read the lines as they stand
					io_rd_d = {io_rd_q[WORD_W-IO_LANES-1:0], bus.iod};
				end
			end else begin
				// falling edge: launch next pair
				io_sh_d   = {io_sh_q[WORD_W+HDR_W-IO_LANES-1:0], 2'h0};
				io_beat_d = io_beat_q + 4'h1;
				io_oe_d   = (io_beat_q == 4'(BEATS - 1)) ? 1'b0 : io_out_q;
				io_dat_d  = io_sh_q[WORD_W-1 -: IO_LANES];
				if (io_beat_q == 4'(BEATS - 1)) begin
					io_act_d  = 1'b0;
					io_done_d = 1'b1;
				end
			end
		end
	end
	always_comb begin
		sys_div_d = sys_div_q - 8'h01;
		sys_d     = sys_q;
		if (sys_div_q == 8'h00) begin
			sys_div_d = 8'(SYS_HALF_CYC - 1);
			sys_d     = !sys_q;
		end
		clr_d = clear_req_i;
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			io_div_q  <= 8'h00;
			io_clk_q  <= 1'b0;
			io_act_q  <= 1'b0;
			io_out_q  <= 1'b0;
			io_beat_q <= 4'h0;
			io_sh_q   <= '0;
			io_rd_q   <= '0;
			io_done_q <= 1'b0;
			io_oe_q   <= 1'b0;
			io_dat_q  <= 2'h0;
			sys_div_q <= 8'h00;
			sys_q     <= 1'b0;
			clr_q     <= 1'b1;
			rq1_q     <= '0;
			rq2_q     <= '0;
			pr1_q     <= '0;
			pr2_q     <= '0;
		end else if (clk_en_i) begin
			io_div_q  <= io_div_d;
			io_clk_q  <= io_clk_d;
			io_act_q  <= io_act_d;
			io_out_q  <= io_out_d;
			io_beat_q <= io_beat_d;
			io_sh_q   <= io_sh_d;
			io_rd_q   <= io_rd_d;
			io_done_q <= io_done_d;
			io_oe_q   <= io_oe_d;
			io_dat_q  <= io_dat_d;
			sys_div_q <= sys_div_d;
			sys_q     <= sys_d;
			clr_q     <= clr_d;
			rq1_q     <= bus.req;
			rq2_q     <= rq1_q;
			pr1_q     <= bus.pri;
			pr2_q     <= pr1_q;
		end
	end
	// header always driven by the processor; data only on output transfers
	assign bus.iod_cpu_o    = io_dat_q;
	assign bus.iod_cpu_oe   = io_oe_q;
	assign bus.ioclk_cpu_o  = io_clk_q;
	assign bus.ioclk_cpu_oe = io_act_q;
	assign bus.sysclk       = sys_q;
	assign bus.clear        = clr_q;
	assign io_busy_o        = io_act_q;
	assign io_done_o        = io_done_q;
	assign io_rdata_o       = io_rd_q;
	assign req_o            = rq2_q;
	assign pri_o            = pr2_q;
endmodule
`default_nettype wire

// ===== hw/cbp_dev_end.sv
// far end: memory board plus one io peripheral
`default_nettype none
module cbp_dev_end
	import cbp_pkg::*;
#(
	parameter int unsigned MEM_WORDS = MEM_WORDS_4K
) (
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              clk_en_i,
	cbp_if.dev                     bus,
	input  wire logic [WORD_W-1:0] io_txdata_i,
	input  wire logic [REQ_N-1:0]  req_i,
	input  wire logic [REQ_N-1:0]  pri_i,
	output logic                   io_rx_o,
	output logic [HDR_W-1:0]       io_hdr_o,
	output logic [WORD_W-1:0]      io_rxdata_o,
	output logic                   cleared_o
);
	localparam int unsigned AW = $clog2(MEM_WORDS);
	// ==========================================================
	// memory board
	logic [WORD_W-1:0] mem [MEM_WORDS];
	logic [AW-1:0]     a_q, a_d;
	logic [WORD_W-1:0] rdo_q, rdo_d;
	logic              rdoe_q, rdoe_d, wr_en;
	logic [3:0]        c1_q, c2_q;
	logic [WORD_W-1:0] ad1_q, ad2_q;

	always_comb begin
		a_d    = a_q;
		rdo_d  = rdo_q;
		rdoe_d = 1'b0;
		wr_en  = 1'b0;
		if (c2_q[CTL_ADDR]) begin
			a_d = ad2_q[AW-1:0];
		end
		if (c2_q[CTL_RD]) begin
			rdo_d  = mem[a_q];
			rdoe_d = 1'b1;
		end
		if (c2_q[CTL_WR] && !c1_q[CTL_WR]) begin
			wr_en = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			a_q    <= '0;
			rdo_q  <= '0;
			rdoe_q <= 1'b0;
			c1_q   <= 4'h0;
			c2_q   <= 4'h0;
			ad1_q  <= '0;
			ad2_q  <= '0;
		end else if (clk_en_i) begin
			a_q    <= a_d;
			rdo_q  <= rdo_d;
			rdoe_q <= rdoe_d;
			c1_q   <= bus.mctl;
			c2_q   <= c1_q;
			ad1_q  <= bus.mad;
			ad2_q  <= ad1_q;
		end
	end
	// write at the end of the write phase, when data has settled
	always_ff @(posedge ref_clk_i) begin
		if (clk_en_i && c1_q[CTL_WR] == 1'b0 && c2_q[CTL_WR] && rst_b_i) begin
			mem[a_q] <= ad2_q;
		end
	end
	assign bus.mad_dev_o  = rdo_q;
	// let go as soon as the read strobe drops, so a following write phase never meets our data
	assign bus.mad_dev_oe = rdoe_q && bus.mctl[CTL_RD] && !wr_en;

	// ==========================================================
	// io peripheral: samples on rising io clock, launches on falling
	logic [2:0]          ck_q;
	logic [IO_LANES-1:0] d1_q, d2_q;
	logic [3:0]          bt_q, bt_d;
	logic [HDR_W-1:0]    hd_q, hd_d;
	logic [WORD_W-1:0]   rx_q, rx_d, tx_q, tx_d;
	logic                rxv_q, rxv_d, clr_q, clr_d, oe_q, oe_d;
	logic [IO_LANES-1:0] do_q, do_d;
	logic [1:0]          cl1_q, cl2_q;

	always_comb begin
		bt_d  = bt_q;
		hd_d  = hd_q;
		rx_d  = rx_q;
		tx_d  = tx_q;
		rxv_d = 1'b0;
		oe_d  = oe_q;
		do_d  = do_q;
		clr_d = cl2_q[1];
		if (ck_q[2:1] == 2'b01) begin
			if (bt_q == 4'h0) begin
				hd_d = d2_q;
				tx_d = io_txdata_i;
			end else begin
				rx_d = {rx_q[WORD_W-IO_LANES-1:0], d2_q};
			end
			if (bt_q == 4'(BEATS - 1)) begin
				bt_d  = 4'h0;
				rxv_d = 1'b1;
				oe_d  = 1'b0;
			end else begin
				bt_d = bt_q + 4'h1;
			end
		end
		if (ck_q[2:1] == 2'b10) begin
			oe_d = (bt_q != 4'h0) && hd_q[0];
			do_d = tx_q[WORD_W-1 -: IO_LANES];
			tx_d = {tx_q[WORD_W-IO_LANES-1:0], 2'h0};
		end
		if (cl2_q[1]) begin
			bt_d = 4'h0;
			oe_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ck_q  <= 3'h0;
			d1_q  <= 2'h0;
			d2_q  <= 2'h0;
			bt_q  <= 4'h0;
			hd_q  <= 2'h0;
			rx_q  <= '0;
			tx_q  <= '0;
			rxv_q <= 1'b0;
			oe_q  <= 1'b0;
			do_q  <= 2'h0;
			clr_q <= 1'b0;
			cl1_q <= 2'h0;
			cl2_q <= 2'h0;
		end else if (clk_en_i) begin
			ck_q  <= {ck_q[1:0], bus.ioclk};
			d1_q  <= bus.iod;
			d2_q  <= d1_q;
			bt_q  <= bt_d;
			hd_q  <= hd_d;
			rx_q  <= rx_d;
			tx_q  <= tx_d;
			rxv_q <= rxv_d;
			oe_q  <= oe_d;
			do_q  <= do_d;
			clr_q <= clr_d;
			cl1_q <= {bus.clear, 1'b0};
			cl2_q <= cl1_q;
		end
	end
	assign bus.iod_dev_o    = do_q;
	assign bus.iod_dev_oe   = oe_q;
	assign bus.ioclk_dev_o  = 1'b0;
	assign bus.ioclk_dev_oe = 1'b0;
	assign bus.req          = req_i;
	assign bus.pri          = pri_i;
	assign io_rx_o          = rxv_q;
	assign io_hdr_o         = hd_q;
	assign io_rxdata_o      = rx_q;
	assign cleared_o        = clr_q;
endmodule
`default_nettype wire

// ===== tb/cbp_chk.sv
// concurrent checks on the bus that joins the two ends
`default_nettype none
module cbp_chk
	import cbp_pkg::*;
(
	input wire logic                ref_clk_i,
	input wire logic                rst_b_i,
	input wire logic [WORD_W-1:0]   mad,
	input wire logic                mad_cpu_oe,
	input wire logic                mad_dev_oe,
	input wire logic [3:0]          mctl,
	input wire logic [IO_LANES-1:0] iod,
	input wire logic                iod_cpu_oe,
	input wire logic                iod_dev_oe,
	input wire logic                ioclk,
	input wire logic                sysclk
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// ==========================================================
	// run length of the address phase
	logic [7:0] alen_q;
	logic [7:0] alen_d;
	always_comb begin
		alen_d = mctl[CTL_ADDR] ? alen_q + 8'h01 : 8'h00;
	end
	always_ff @(posedge ref_clk_i) begin
		alen_q <= rst_b_i ? alen_d : 8'h00;
	end
	// ==========================================================
	// memory path
	mad_drive_excl_a: assert property (!(mad_cpu_oe && mad_dev_oe))
		else $error("both ends drive the memory path");
	mad_dev_dir_a: assert property (mad_dev_oe |-> (mctl[CTL_RD] || $past(mctl[CTL_RD])))
		else $error("device drives outside a read phase");
	mad_cpu_dir_a: assert property (mad_cpu_oe |-> (mctl[CTL_ADDR] || mctl[CTL_WR]
		|| $past(mctl[CTL_ADDR]) || $past(mctl[CTL_WR])))
		else $error("processor drives during a read phase");
	addr_hold_a: assert property ((mctl[CTL_ADDR] && $past(mctl[CTL_ADDR], 2)) |-> $stable(mad))
		else $error("address moved during the address phase");
	addr_len_a: assert property ($fell(mctl[CTL_ADDR]) |-> alen_q == 8'(MEM_PHASE_CYC))
		else $error("address phase length wrong");
	rd_order_a: assert property ($rose(mctl[CTL_RD]) |-> $past(mctl[CTL_ADDR]))
		else $error("read phase without address phase");
	wr_order_a: assert property ($rose(mctl[CTL_WR]) |-> ($past(mctl[CTL_ADDR]) || $past(mctl[CTL_RD])))
		else $error("write phase out of order");
	// ==========================================================
	// io link
	iod_drive_excl_a: assert property (!(iod_cpu_oe && iod_dev_oe))
		else $error("both ends drive the io data lines");
	iod_hold_a: assert property ($rose(ioclk) |=> $stable(iod))
		else $error("io data moved at the sampling edge");
	ioclk_half_a: assert property ($rose(ioclk) |-> ioclk [*4] ##1 !ioclk)
		else $error("io clock high time wrong");
	sysclk_half_a: assert property ($rose(sysclk) |-> sysclk [*2] ##1 !sysclk)
		else $error("system clock high time wrong");
endmodule
`default_nettype wire

// ===== tb/cpu_board_bus_ports_tb_top.sv
// top bench: both ends joined, driven from their user sides
`default_nettype none
module cpu_board_bus_ports_tb_top
	import cbp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LAT1 = int'(MEM_PHASE_CYC + 1);
	localparam int LAT2 = int'(2 * MEM_PHASE_CYC + 1);
	localparam int LAT3 = int'(3 * MEM_PHASE_CYC + 1);
	logic              ref_clk_i = 1'b0;
	logic              rst_b_i = 1'b0;
	logic              mem_req_i = 1'b0;
	logic [1:0]        mem_op_i = 2'h0;
	logic [WORD_W-1:0] mem_addr_i = 16'h0000;
	logic [WORD_W-1:0] mem_wdata_i = 16'h0000;
	logic              io_req_i = 1'b0;
	logic              io_dir_out_i = 1'b0;
	logic [HDR_W-1:0]  io_hdr_i = 2'h0;
	logic [WORD_W-1:0] io_wdata_i = 16'h0000;
	logic              clear_req_i = 1'b0;
	logic              ovr_i = 1'b0;
	logic [3:0]        ovr_mctl_i = 4'h0;
	logic [REQ_N-1:0]  req_i = 2'h0;
	logic [REQ_N-1:0]  pri_i = 2'h0;
	logic              mem_busy_o, mem_done_o, io_busy_o, io_done_o, io_rx_o, cleared_o;
	logic [WORD_W-1:0] mem_rdata_o, io_rdata_o, io_rxdata_o;
	logic [REQ_N-1:0]  req_o, pri_o;
	logic [HDR_W-1:0]  io_hdr_o;
	logic              clk_seen_q = 1'b0;
	logic [17:0]       cap = 18'h00000;
	int                io_fins = 0;
	int                rx_fins = 0;
	int                beats = 0;
	int                miscompares = 0;
	int                compares = 0;
	always #(CLK_NS / 2) ref_clk_i = ~ref_clk_i;
	cbp_if bus_if ();
	cbp_cpu_end i_cbp_cpu_end (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .bus(bus_if),
		.mem_req_i(mem_req_i), .mem_op_i(mem_op_i), .mem_addr_i(mem_addr_i),
		.mem_wdata_i(mem_wdata_i), .mem_busy_o(mem_busy_o), .mem_done_o(mem_done_o),
		.mem_rdata_o(mem_rdata_o), .io_req_i(io_req_i), .io_dir_out_i(io_dir_out_i),
		.io_hdr_i(io_hdr_i), .io_wdata_i(io_wdata_i), .io_busy_o(io_busy_o),
		.io_done_o(io_done_o), .io_rdata_o(io_rdata_o), .clear_req_i(clear_req_i),
		.ovr_i(ovr_i), .ovr_mctl_i(ovr_mctl_i), .req_o(req_o), .pri_o(pri_o)
	);
	cbp_dev_end #(.MEM_WORDS(MEM_WORDS_2K)) i_cbp_dev_end (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .bus(bus_if),
		.io_txdata_i(16'h3CC3), .req_i(req_i), .pri_i(pri_i), .io_rx_o(io_rx_o),
		.io_hdr_o(io_hdr_o), .io_rxdata_o(io_rxdata_o), .cleared_o(cleared_o)
	);
	cbp_chk u_chk (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .mad(bus_if.mad),
		.mad_cpu_oe(bus_if.mad_cpu_oe), .mad_dev_oe(bus_if.mad_dev_oe), .mctl(bus_if.mctl),
		.iod(bus_if.iod), .iod_cpu_oe(bus_if.iod_cpu_oe), .iod_dev_oe(bus_if.iod_dev_oe),
		.ioclk(bus_if.ioclk), .sysclk(bus_if.sysclk)
	);
	// ==========================================================
	// wire monitor: bit pairs as seen at each rising io clock
	always @(posedge ref_clk_i) begin
		clk_seen_q <= bus_if.ioclk;
		if (bus_if.ioclk && !clk_seen_q) begin
			cap <= {cap[15:0], bus_if.iod};
			beats <= beats + 1;
		end
		if (io_done_o === 1'b1) io_fins <= io_fins + 1;
		if (io_rx_o === 1'b1) rx_fins <= rx_fins + 1;
	end
	// ==========================================================
	// compares and closing
	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_cnt(input string what, input int exp, input int got);
		compares++;
		if (got != exp) begin
			miscompares++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic hang(input string what);
		miscompares++;
		$display("mismatch %s expected done seen timeout", what);
		final_report();
	endtask
	task automatic test_end(input string what);
		$display("test %s finished", what);
	endtask
	// ==========================================================
	// access tasks
	task automatic mem_cyc(input logic [1:0] op, input logic [15:0] a, input logic [15:0] w,
		input int lat, output logic [15:0] rd);
		int n;
		@(posedge ref_clk_i);
		mem_req_i <= 1'b1;
		mem_op_i <= op;
		mem_addr_i <= a;
		mem_wdata_i <= w;
		@(posedge ref_clk_i);
		mem_req_i <= 1'b0;
		#1;
		chk_val("mem busy", 32'h1, 32'(mem_busy_o));
		n = 1;
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while (mem_done_o !== 1'b1 && n < 200);
		if (mem_done_o !== 1'b1) hang("mem done");
		chk_cnt("mem latency", lat, n);
		rd = mem_rdata_o;
	endtask
	task automatic io_xfer(input logic d_out, input logic [1:0] h, input logic [15:0] w);
		int n;
		int b0;
		int f0;
		int r0;
		@(posedge ref_clk_i);
		b0 = beats;
		f0 = io_fins;
		r0 = rx_fins;
		io_req_i <= 1'b1;
		io_dir_out_i <= d_out;
		io_hdr_i <= h;
		io_wdata_i <= w;
		@(posedge ref_clk_i);
		io_req_i <= 1'b0;
		#1;
		chk_val("io busy", 32'h1, 32'(io_busy_o));
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while ((io_fins == f0 || (d_out && rx_fins == r0)) && n < 300);
		if (io_fins == f0 || (d_out && rx_fins == r0)) hang("io done");
		chk_cnt("io beats", int'(BEATS), beats - b0);
		chk_val("io wire word", 32'({h, d_out ? w : 16'h3CC3}), 32'(cap));
	endtask
	// ==========================================================
	// main sequence
	initial begin
		logic [15:0] rd;
		repeat (5) @(posedge ref_clk_i);
		#1;
		chk_val("clear in reset", 32'h1, 32'(bus_if.clear));
		@(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		#1;
		chk_val("clear idle", 32'h0, 32'(bus_if.clear));
		@(posedge ref_clk_i);
		clear_req_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		#1;
		chk_val("clear line", 32'h1, 32'(bus_if.clear));
		chk_val("peripheral cleared", 32'h1, 32'(cleared_o));
		@(posedge ref_clk_i);
		clear_req_i <= 1'b0;
		test_end("clear");
		mem_cyc(CBP_MEM_WRITE, 16'h0010, 16'h1234, LAT2, rd);
		mem_cyc(CBP_MEM_READ, 16'h0010, 16'h0000, LAT2, rd);
		chk_val("read word", 32'h1234, 32'(rd));
		mem_cyc(CBP_MEM_RMW, 16'h0010, 16'hBEEF, LAT3, rd);
		chk_val("rmw old word", 32'h1234, 32'(rd));
		mem_cyc(CBP_MEM_READ, 16'h0010, 16'h0000, LAT2, rd);
		chk_val("rmw new word", 32'hBEEF, 32'(rd));
		mem_cyc(CBP_MEM_WRITE, 16'h0815, 16'h5A5A, LAT2, rd);
		mem_cyc(CBP_MEM_READ, 16'h0015, 16'h0000, LAT2, rd);
		chk_val("wrapped word", 32'h5A5A, 32'(rd));
		mem_cyc(CBP_MEM_REFRESH, 16'h0000, 16'h0000, LAT1, rd);
		test_end("memory");
		io_xfer(1'b1, 2'h2, 16'hA55A);
		chk_val("rx header", 32'h2, 32'(io_hdr_o));
		chk_val("rx word", 32'hA55A, 32'(io_rxdata_o));
		io_xfer(1'b0, 2'h1, 16'h0000);
		chk_val("tx word", 32'h3CC3, 32'(io_rdata_o));
		test_end("io link");
		for (int v = 1; v < 3; v++) begin
			@(posedge ref_clk_i);
			req_i <= 2'(v);
			pri_i <= 2'(3 - v);
			repeat (4) @(posedge ref_clk_i);
			#1;
			chk_val("request lines", 32'(v), 32'(req_o));
			chk_val("priority lines", 32'(3 - v), 32'(pri_o));
		end
		test_end("requests");
		@(posedge ref_clk_i);
		ovr_mctl_i <= 4'h8;
		ovr_i <= 1'b1;
		mem_req_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk_val("override controls", 32'h8, 32'(bus_if.mctl));
		chk_val("override gates cycle", 32'h0, 32'(mem_busy_o));
		@(posedge ref_clk_i);
		ovr_i <= 1'b0;
		mem_req_i <= 1'b0;
		test_end("override");
		final_report();
	end
endmodule
`default_nettype wire
